// ---- cbec_comparator_b.sv ----
// Summary of operation
// - The two-bit positive select routes analog pin one, two, three or four for codes 0 to 3.
// - The input-connect bit connects the analog pins to the comparator when 1 and isolates them when 0.
// - The event flag is set when the comparator output meets the chosen mode while the enable bit is set.
// - The event flag stays set until software clears it; hardware never clears it.
// - The CPU request from the flag passes only while bit 6 of the interrupt-enable register is set.
// - With enable clear the comparator output is held low and no event can set the flag.
// - With enable set the four analog pins have their digital inputs forced to input-only.
// - Mode codes 0 to 7 are low level, rise, debounced toggle, debounced rise, fall, toggle, debounced fall, high level.
// - Debounced modes qualify the output only at Timer 1 sampling ticks.
`timescale 1ns/100ps
module cbec_comparator_b
	import cbec_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// register port
	input wire logic [cbec_pkg::ADDR_W-1:0] regAddr,
	input wire logic [cbec_pkg::DATA_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [cbec_pkg::DATA_W-1:0] regRdData,
	// analog comparator and timer
	input wire logic cmpRaw,
	input wire logic timer1Tick,
	output logic cmpOut,
	output logic [3:0] posRoute,
	output logic inputConnect,
	output logic [1:0] negInputSel,
	output logic [3:0] pinInputOnly,
	// interrupts
	output logic cpuIrqReq,
	output logic irq
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [1:0] syncCmp;
		logic cmpOut;
		logic cmpPrev;
		logic dbPrev;
		logic [1:0] posSel;
		logic connect;
		logic flag;
		logic enable;
		logic [2:0] mode;
		logic [1:0] negSel;
		logic [7:0] intEn;
		logic [EVT_W-1:0] evtStatus;
		logic [EVT_W-1:0] evtEnable;
		logic [3:0] posRoute;
		logic [3:0] pinInputOnly;
		logic cpuIrqReq;
		logic irq;
		logic [DATA_W-1:0] rdData;
	} cbec_state_s;

	cbec_state_s st;
	cbec_state_s next_st;
	logic dbLevel;
	logic hit;
	logic wrCtrl;
	logic wrClr;

	function automatic logic [3:0] cbec_onehot(input logic [1:0] sel, input logic on);
		logic [3:0] r;
		r = 4'h0;
		if (on)
			r[sel] = 1'b1;
		return r;
	endfunction : cbec_onehot

	function automatic logic [7:0] cbec_ctrl_word(input cbec_state_s s);
		return {s.posSel, s.connect, s.flag, s.enable, s.mode};
	endfunction : cbec_ctrl_word

	function automatic logic cbec_wr_at(input logic wr, input logic [7:0] addr, input logic [7:0] ofs);
		return wr && (addr == ofs);
	endfunction : cbec_wr_at

	// ----------------------------------------------------------------
	// debounce on timer ticks
	// ----------------------------------------------------------------
	cbec_debounce i_cbec_debounce
	(
		.clk(clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.sampleTick(timer1Tick),
		.level(st.cmpOut),
		.stable(dbLevel)
	);

	// ----------------------------------------------------------------
	// trigger decode
	// ----------------------------------------------------------------
	always_comb
	begin
		unique case (cbec_mode_e'(st.mode))
			CBEC_LOW_LEVEL: hit = !st.cmpOut;
			CBEC_RISE: hit = st.cmpOut && !st.cmpPrev;
			CBEC_DB_TOGGLE: hit = dbLevel != st.dbPrev;
			CBEC_DB_RISE: hit = dbLevel && !st.dbPrev;
			CBEC_FALL: hit = !st.cmpOut && st.cmpPrev;
			CBEC_TOGGLE: hit = st.cmpOut != st.cmpPrev;
			CBEC_DB_FALL: hit = !dbLevel && st.dbPrev;
			CBEC_HIGH_LEVEL: hit = st.cmpOut;
		endcase
		hit = hit && st.enable;
	end

	assign wrCtrl = cbec_wr_at(regWr, regAddr, OFS_CTRL);
	assign wrClr = cbec_wr_at(regWr, regAddr, OFS_EVT_CLEAR);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		next_st.syncCmp = {st.syncCmp[0], cmpRaw};
		next_st.cmpOut = st.syncCmp[1] && st.enable;
		next_st.cmpPrev = st.cmpOut;
		next_st.dbPrev = dbLevel;

		// register writes
		if (wrCtrl)
		begin
			next_st.posSel = regWrData[POS_SEL_HI:POS_SEL_LO];
			next_st.connect = regWrData[POS_CONNECT];
			next_st.enable = regWrData[POS_ENABLE];
			next_st.mode = regWrData[POS_MODE_HI:POS_MODE_LO];
		end
		if (cbec_wr_at(regWr, regAddr, OFS_INTEN))
			next_st.intEn = regWrData;
		if (cbec_wr_at(regWr, regAddr, OFS_NEGSEL))
			next_st.negSel = regWrData[1:0];
		if (cbec_wr_at(regWr, regAddr, OFS_EVT_ENABLE))
			next_st.evtEnable = regWrData[EVT_W-1:0];

		// flag: writing 0 clears, set wins over clear
		if (wrCtrl && !regWrData[POS_FLAG])
			next_st.flag = 1'b0;
		if (hit)
			next_st.flag = 1'b1;

		// sticky events
		if (wrClr)
			next_st.evtStatus = st.evtStatus & ~regWrData[EVT_W-1:0];
		if (hit)
			next_st.evtStatus[POS_EVT_TRIG] = 1'b1;
		if (st.enable && (dbLevel != st.dbPrev))
			next_st.evtStatus[POS_EVT_DEB] = 1'b1;

		// outputs
		next_st.posRoute = cbec_onehot(next_st.posSel, next_st.connect);
		next_st.pinInputOnly = {4{next_st.enable}};
		next_st.cpuIrqReq = next_st.flag && next_st.intEn[POS_IE_CMP];
		next_st.irq = |(next_st.evtStatus & next_st.evtEnable);

		// read data stands only in the cycle after the strobe
		next_st.rdData = '0;
		if (regRd)
		begin
			unique case (regAddr)
				OFS_CTRL: next_st.rdData = cbec_ctrl_word(st);
				OFS_INTEN: next_st.rdData = st.intEn;
				OFS_NEGSEL: next_st.rdData = {6'h0, st.negSel};
				OFS_EVT_STATUS: next_st.rdData = {6'h0, st.evtStatus};
				OFS_EVT_ENABLE: next_st.rdData = {6'h0, st.evtEnable};
				default: next_st.rdData = '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st <= '0;
			st.posSel <= RST_CTRL[POS_SEL_HI:POS_SEL_LO];
			st.connect <= RST_CTRL[POS_CONNECT];
			st.flag <= RST_CTRL[POS_FLAG];
			st.enable <= RST_CTRL[POS_ENABLE];
			st.mode <= RST_CTRL[POS_MODE_HI:POS_MODE_LO];
			st.intEn <= RST_INTEN;
			st.negSel <= RST_NEGSEL;
			st.evtStatus <= RST_EVT;
			st.evtEnable <= RST_EVT;
		end
		else if (clkEn)
			st <= next_st;
	end

	assign regRdData = st.rdData;
	assign cmpOut = st.cmpOut;
	assign posRoute = st.posRoute;
	assign inputConnect = st.connect;
	assign negInputSel = st.negSel;
	assign pinInputOnly = st.pinInputOnly;
	assign cpuIrqReq = st.cpuIrqReq;
	assign irq = st.irq;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	route_select_a: assert property (@(posedge clk) disable iff (!rst_b)
		$past(clkEn) && st.connect |-> posRoute == (4'h1 << st.posSel))
		else $error("positive route does not follow select");

	route_isolate_a: assert property (@(posedge clk) disable iff (!rst_b)
		!st.connect |-> posRoute == 4'h0)
		else $error("pins routed while input connect is clear");

	flag_set_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && hit |=> st.flag)
		else $error("trigger did not set the event flag");

	flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && st.flag && !(wrCtrl && !regWrData[POS_FLAG]) |=> st.flag)
		else $error("event flag cleared without a software write");

	cpu_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
		$past(clkEn) |-> cpuIrqReq == (st.flag && st.intEn[POS_IE_CMP]))
		else $error("cpu request not gated by interrupt enable bit");

	disabled_low_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && !st.enable ##1 clkEn && !st.enable |=> !cmpOut)
		else $error("comparator output high while disabled");

	disabled_noset_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && !st.enable && !st.flag && !$past(hit) |=> !st.flag)
		else $error("flag set while comparator disabled");

	input_only_a: assert property (@(posedge clk) disable iff (!rst_b)
		$past(clkEn) |-> pinInputOnly == {4{st.enable}})
		else $error("pin input-only mode does not follow enable");

	rise_mode_a: assert property (@(posedge clk) disable iff (!rst_b)
		st.enable && st.mode == CBEC_RISE && st.cmpOut && !st.cmpPrev |-> hit)
		else $error("rising edge missed in edge mode");

	level_repeat_a: assert property (@(posedge clk) disable iff (!rst_b)
		st.enable && st.mode == CBEC_HIGH_LEVEL && st.cmpOut |-> hit)
		else $error("high level not raising the trigger");

	irq_level_a: assert property (@(posedge clk) disable iff (!rst_b)
		$past(clkEn) |-> irq == |(st.evtStatus & st.evtEnable))
		else $error("interrupt output not matching enabled status");

	read_once_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && !regRd |=> regRdData == '0)
		else $error("read data present without read strobe");

	// ----------------------------------------------------------------
	// checks: trigger modes
	// ----------------------------------------------------------------
	low_level_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && st.enable && st.mode == CBEC_LOW_LEVEL && !st.cmpOut |=> st.flag)
		else $error("low level did not set the event flag");

	fall_mode_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && st.enable && st.mode == CBEC_FALL && !st.cmpOut && st.cmpPrev |=> st.flag)
		else $error("falling edge did not set the event flag");

	toggle_mode_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && st.enable && st.mode == CBEC_TOGGLE && st.cmpOut != st.cmpPrev |=> st.flag)
		else $error("toggle did not set the event flag");

	high_level_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && st.enable && st.mode == CBEC_HIGH_LEVEL && st.cmpOut |=> st.flag)
		else $error("high level did not set the event flag");

	db_toggle_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && st.enable && st.mode == CBEC_DB_TOGGLE && dbLevel != st.dbPrev |=> st.flag)
		else $error("debounced toggle did not set the event flag");

	db_rise_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && st.enable && st.mode == CBEC_DB_RISE && dbLevel && !st.dbPrev |=> st.flag)
		else $error("debounced rise did not set the event flag");

	db_fall_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && st.enable && st.mode == CBEC_DB_FALL && !dbLevel && st.dbPrev |=> st.flag)
		else $error("debounced fall did not set the event flag");

	toggle_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
		st.mode == CBEC_TOGGLE && st.cmpOut == st.cmpPrev |-> !hit)
		else $error("toggle trigger without a change of output");

	prev_track_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn |=> st.cmpPrev == $past(st.cmpOut))
		else $error("previous output sample not tracking");

	sync_path_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && st.enable |=> cmpOut == $past(st.syncCmp[1]))
		else $error("comparator output not following synchronised input");

	cmp_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
		$past(clkEn) && cmpOut |-> $past(st.enable))
		else $error("comparator output high without enable");

	hit_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
		!st.enable |-> !hit)
		else $error("trigger raised while comparator disabled");

	// ----------------------------------------------------------------
	// checks: register writes
	// ----------------------------------------------------------------
	sel_write_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && wrCtrl |=> st.posSel == $past(regWrData[POS_SEL_HI:POS_SEL_LO]))
		else $error("positive select not taken from write");

	connect_write_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && wrCtrl |=> inputConnect == $past(regWrData[POS_CONNECT]))
		else $error("input connect not taken from write");

	enable_write_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && wrCtrl |=> pinInputOnly == {4{$past(regWrData[POS_ENABLE])}})
		else $error("input-only pins not following written enable");

	mode_write_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && wrCtrl |=> st.mode == $past(regWrData[POS_MODE_HI:POS_MODE_LO]))
		else $error("trigger mode not taken from write");

	flag_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && wrCtrl && !regWrData[POS_FLAG] && !hit |=> !st.flag)
		else $error("software clear of event flag ignored");

	ie_write_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && regWr && regAddr == OFS_INTEN |=> st.intEn == $past(regWrData))
		else $error("interrupt enable register not taken from write");

	evt_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && st.evtStatus[POS_EVT_TRIG] && !(wrClr && regWrData[POS_EVT_TRIG]) |=> st.evtStatus[POS_EVT_TRIG])
		else $error("event status cleared without a software write");

	state_frozen_a: assert property (@(posedge clk) disable iff (!rst_b)
		!clkEn |=> $stable(st))
		else $error("state moved while clock enable low");

endmodule : cbec_comparator_b

// ---- cbec_pkg.sv ----
package cbec_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_INTEN = 8'h01;
	localparam logic [7:0] OFS_NEGSEL = 8'h02;
	localparam logic [7:0] OFS_EVT_STATUS = 8'h03;
	localparam logic [7:0] OFS_EVT_CLEAR = 8'h04;
	localparam logic [7:0] OFS_EVT_ENABLE = 8'h05;

	// ----------------------------------------------------------------
	// control/status field positions
	// ----------------------------------------------------------------
	localparam int POS_SEL_HI = 7;
	localparam int POS_SEL_LO = 6;
	localparam int POS_CONNECT = 5;
	localparam int POS_FLAG = 4;
	localparam int POS_ENABLE = 3;
	localparam int POS_MODE_HI = 2;
	localparam int POS_MODE_LO = 0;
	localparam int POS_IE_CMP = 6;
	localparam int POS_EVT_TRIG = 0;
	localparam int POS_EVT_DEB = 1;
	localparam int EVT_W = 2;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CTRL = 8'hC0;
	localparam logic [7:0] RST_INTEN = 8'h00;
	localparam logic [1:0] RST_NEGSEL = 2'h0;
	localparam logic [1:0] RST_EVT = 2'h0;

	// ----------------------------------------------------------------
	// trigger modes
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		CBEC_LOW_LEVEL = 3'h0,
		CBEC_RISE = 3'h1,
		CBEC_DB_TOGGLE = 3'h2,
		CBEC_DB_RISE = 3'h3,
		CBEC_FALL = 3'h4,
		CBEC_TOGGLE = 3'h5,
		CBEC_DB_FALL = 3'h6,
		CBEC_HIGH_LEVEL = 3'h7
	} cbec_mode_e;

endpackage : cbec_pkg

// ---- cbec_debounce.sv ----
`timescale 1ns/100ps
module cbec_debounce
	import cbec_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// sampling
	input wire logic sampleTick,
	input wire logic level,
	// result
	output logic stable
);
	typedef struct packed
	{
		logic lastSample;
		logic stable;
	} cbec_db_s;

	cbec_db_s st;
	cbec_db_s next_st;

	// ----------------------------------------------------------------
	// two agreeing samples at timer ticks move the stable value
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		if (sampleTick)
		begin
			next_st.lastSample = level;
			if (level == st.lastSample)
				next_st.stable = level;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			st <= '0;
		else if (clkEn)
			st <= next_st;
	end

	assign stable = st.stable;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	db_tick_only_a: assert property (@(posedge clk) disable iff (!rst_b)
		!$past(clkEn && sampleTick) |-> $stable(st.stable))
		else $error("debounced value moved without a sampling tick");

endmodule : cbec_debounce

// ---- cbec_comparator_b_test.sv ----
`timescale 1ns/100ps
module cbec_comparator_b_test;
	import cbec_pkg::*;
	`define CHECK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
		$display("CHECK FAILED at %0t: got %h want %h", $time, a, e); end end
	typedef struct packed {logic [2:0] mode; logic init; logic fin; logic exp;} cbec_row_s;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic clkEn = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [7:0] regRdData;
	logic cmpRaw = 1'b0;
	logic timer1Tick = 1'b0;
	logic cmpOut;
	logic [3:0] posRoute;
	logic inputConnect;
	logic [1:0] negInputSel;
	logic [3:0] pinInputOnly;
	logic cpuIrqReq;
	logic irq;
	logic [7:0] d;
	int n_mismatch = 0;
	int check_count = 0;
	cbec_row_s rows [15] = '{
		{3'h0, 1'b1, 1'b0, 1'b1}, {3'h0, 1'b1, 1'b1, 1'b0}, {3'h7, 1'b0, 1'b1, 1'b1}, {3'h7, 1'b0, 1'b0, 1'b0},
		{3'h1, 1'b0, 1'b1, 1'b1}, {3'h1, 1'b1, 1'b0, 1'b0}, {3'h4, 1'b1, 1'b0, 1'b1}, {3'h4, 1'b0, 1'b1, 1'b0},
		{3'h5, 1'b0, 1'b1, 1'b1}, {3'h5, 1'b1, 1'b0, 1'b1}, {3'h2, 1'b0, 1'b1, 1'b0}, {3'h3, 1'b0, 1'b1, 1'b0},
		{3'h6, 1'b1, 1'b0, 1'b0}, {3'h1, 1'b0, 1'b0, 1'b0}, {3'h4, 1'b1, 1'b1, 1'b0}};

	cbec_comparator_b i_cbec_comparator_b (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .cmpRaw(cmpRaw),
		.timer1Tick(timer1Tick), .cmpOut(cmpOut), .posRoute(posRoute), .inputConnect(inputConnect),
		.negInputSel(negInputSel), .pinInputOnly(pinInputOnly), .cpuIrqReq(cpuIrqReq), .irq(irq));

	always #50 clk = ~clk;

	// ----------------------------------------------------------------
	// bus and stimulus tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		regAddr <= a;
		regWrData <= v;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		@(negedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		d = regRdData;
	endtask : rd

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : cyc

	task automatic setRaw(input logic v);
		@(posedge clk);
		cmpRaw <= v;
	endtask : setRaw

	task automatic tick();
		@(posedge clk);
		timer1Tick <= 1'b1;
		@(posedge clk);
		timer1Tick <= 1'b0;
	endtask : tick

	task automatic waitIrq(input int lim);
		int i;
		i = 0;
		while (cpuIrqReq !== 1'b1 && i < lim)
		begin
			@(negedge clk);
			i++;
		end
		`CHECK(cpuIrqReq, 1'b1)
		if (cpuIrqReq !== 1'b1)
			conclude();
	endtask : waitIrq

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	initial
	begin
		#(100 * 20000);
		n_mismatch++;
		$display("CHECK FAILED at %0t: run timed out", $time);
		conclude();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (2) @(posedge clk);
		`CHECK({posRoute, pinInputOnly, cpuIrqReq, irq, cmpOut}, 11'h000)
		rst_b <= 1'b1;
		rd(OFS_CTRL);
		`CHECK(d, RST_CTRL)
		rd(OFS_INTEN);
		`CHECK(d, 8'h00)
		wr(OFS_INTEN, 8'h40);
		wr(OFS_EVT_ENABLE, 8'h01);
		$display("test reset done");
		foreach (rows[k])
		begin
			wr(OFS_CTRL, 8'h00);
			setRaw(rows[k].init);
			cyc(4);
			wr(OFS_CTRL, {5'h01, rows[k].mode});
			cyc(6);
			wr(OFS_CTRL, {5'h01, rows[k].mode});
			wr(OFS_EVT_CLEAR, 8'h03);
			cyc(2);
			setRaw(rows[k].fin);
			cyc(6);
			rd(OFS_CTRL);
			`CHECK(d[POS_FLAG], rows[k].exp)
			`CHECK(cpuIrqReq, rows[k].exp)
			`CHECK(irq, rows[k].exp)
		end
		$display("test modes done");
		for (int s = 0; s < 4; s++)
		begin
			wr(OFS_CTRL, {s[1:0], 6'h08});
			wr(OFS_CTRL, {s[1:0], 6'h28});
			`CHECK(posRoute, 4'h1 << s)
			`CHECK(inputConnect, 1'b1)
			`CHECK(pinInputOnly, 4'hF)
		end
		wr(OFS_CTRL, 8'h08);
		`CHECK(posRoute, 4'h0)
		wr(OFS_NEGSEL, 8'h03);
		`CHECK(negInputSel, 2'h3)
		wr(OFS_CTRL, 8'h00);
		`CHECK(pinInputOnly, 4'h0)
		$display("test routing done");
		setRaw(1'b0);
		wr(OFS_CTRL, 8'h09);
		wr(OFS_EVT_CLEAR, 8'h03);
		setRaw(1'b1);
		waitIrq(20);
		cyc(30);
		rd(OFS_CTRL);
		`CHECK(d[POS_FLAG], 1'b1)
		wr(OFS_INTEN, 8'h00);
		`CHECK(cpuIrqReq, 1'b0)
		wr(OFS_CTRL, 8'h19);
		wr(OFS_INTEN, 8'h40);
		`CHECK(cpuIrqReq, 1'b1)
		wr(OFS_EVT_STATUS, 8'h00);
		rd(OFS_EVT_STATUS);
		`CHECK(d[POS_EVT_TRIG], 1'b1)
		wr(OFS_EVT_ENABLE, 8'h00);
		`CHECK(irq, 1'b0)
		wr(OFS_EVT_ENABLE, 8'h01);
		`CHECK(irq, 1'b1)
		wr(OFS_EVT_CLEAR, 8'h01);
		cyc(1);
		`CHECK(irq, 1'b0)
		rd(8'h07);
		`CHECK(d, 8'h00)
		$display("test sticky done");
		wr(OFS_CTRL, 8'h0F);
		cyc(6);
		`CHECK(cmpOut, 1'b1)
		wr(OFS_CTRL, 8'h07);
		cyc(6);
		`CHECK(cmpOut, 1'b0)
		wr(OFS_CTRL, 8'h07);
		cyc(6);
		rd(OFS_CTRL);
		`CHECK(d[POS_FLAG], 1'b0)
		$display("test disable done");
		setRaw(1'b0);
		wr(OFS_CTRL, 8'h0B);
		cyc(6);
		wr(OFS_CTRL, 8'h0B);
		setRaw(1'b1);
		cyc(10);
		`CHECK(cpuIrqReq, 1'b0)
		tick();
		cyc(3);
		tick();
		waitIrq(20);
		rd(OFS_EVT_STATUS);
		`CHECK(d[POS_EVT_DEB], 1'b1)
		$display("test debounce done");
		@(posedge clk);
		clkEn <= 1'b0;
		wr(OFS_INTEN, 8'h00);
		`CHECK(cpuIrqReq, 1'b1)
		@(posedge clk);
		clkEn <= 1'b1;
		cyc(1);
		`CHECK(cpuIrqReq, 1'b1)
		$display("test freeze done");
		@(posedge clk);
		rst_b <= 1'b0;
		cyc(1);
		`CHECK({posRoute, pinInputOnly, cpuIrqReq, irq, cmpOut}, 11'h000)
		@(posedge clk);
		rst_b <= 1'b1;
		rd(OFS_CTRL);
		`CHECK(d, RST_CTRL)
		$display("test second reset done");
		conclude();
	end
endmodule : cbec_comparator_b_test
